// ---- bench/cif_host_model.sv ----
// Host model: issues one quadlet read or write at a time to the register set.
// Assumes the bench calls xfer from a single process.
module cif_host_model (
  // Clock
  input  wire logic        clock,
  // Request
  output logic             req_valid,
  output logic             req_write,
  output logic [47:0]      req_addr,
  output logic [31:0]      req_wdata,
  input  wire logic        req_ready,
  // Response
  input  wire logic        resp_valid,
  input  wire logic [31:0] resp_rdata,
  input  wire logic [3:0]  resp_rcode
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr  = 48'h0;
    req_wdata = 32'h0;
  end

  // Hold the request until taken, then wait for its answer
  task automatic xfer(input logic w, input logic [47:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic [3:0] rc);
    int n;
    n = 0;
    @(posedge clock);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr  <= a;
    req_wdata <= wd;
    do begin
      @(posedge clock);
      n++;
    end while (req_ready !== 1'b1 && n < 200);
    // Released lines show the inverse, never a stale copy
    req_valid <= 1'b0;
    req_write <= ~w;
    req_addr  <= ~a;
    req_wdata <= ~wd;
    do begin
      @(posedge clock);
      n++;
    end while (resp_valid !== 1'b1 && n < 400);
    rd = resp_rdata;
    rc = (n < 400) ? resp_rcode : 4'hx;
  endtask
endmodule

// ---- bench/custom_image_format_csr_bench.sv ----
// Self-checking bench for the custom image format register set.
// Assumes default parameters: no feature bytes, packet ceiling 4092.
module custom_image_format_csr_bench import cif_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clock;
  logic        sys_rst;
  logic        req_valid;
  logic        req_write;
  logic [47:0] req_addr;
  logic [31:0] req_wdata;
  logic        req_ready;
  logic        resp_valid;
  logic [31:0] resp_rdata;
  logic [3:0]  resp_rcode;
  logic [15:0] region_left;
  logic [15:0] region_top;
  logic [15:0] region_width;
  logic [15:0] region_height;
  logic [15:0] packet_bytes;
  logic [31:0] frame_packets;
  logic        region_is_vga;
  logic [47:0] base_r;
  int          fails;
  int          checked;
  int          cycles;

  cif_csr u_cif_csr (.clock(clock), .sys_rst(sys_rst), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_ready(req_ready), .resp_valid(resp_valid), .resp_rdata(resp_rdata),
    .resp_rcode(resp_rcode), .region_left(region_left), .region_top(region_top),
    .region_width(region_width), .region_height(region_height),
    .packet_bytes(packet_bytes), .frame_packets(frame_packets),
    .region_is_vga(region_is_vga));

  cif_host_model u_cif_host_model (.clock(clock), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_ready(req_ready), .resp_valid(resp_valid), .resp_rdata(resp_rdata),
    .resp_rcode(resp_rcode));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic tally_and_finish();
    $display("fails %0d checked %0d", fails, checked);
    if (fails == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      fails++;
      tally_and_finish();
    end
  end

  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected data at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_code(input logic [3:0] got, input logic [3:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected code at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One access; writes answer with zero data
  task automatic acc(input logic w, input logic [7:0] o, input logic [31:0] wd,
                     input logic [31:0] ed, input logic [3:0] ec);
    logic [31:0] rd;
    logic [3:0]  rc;
    u_cif_host_model.xfer(w, base_r + 48'(o), wd, rd, rc);
    chk_data(rd, w ? 32'h0 : ed);
    chk_code(rc, ec);
  endtask

  task automatic t_reset_values();
    logic [7:0]  ot [15] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h24, 8'h34,
                             8'h38, 8'h3c, 8'h40, 8'h44, 8'h4c, 8'h54, 8'h58};
    logic [31:0] et [15] = '{32'h0290_01eb, 32'h0001_0001, 32'h0, 32'h0290_01eb, 32'h0,
                             32'h8000_0000, 32'h0, 32'h0004_ea30, 32'h0, 32'h0004_ea30,
                             32'h0004_0ffc, 32'h0ffc_0ffc, 32'h0001_0001, 32'h0800_0000,
                             32'h0};
    for (int i = 0; i < 15; i++) begin
      acc(1'b0, ot[i], 32'h0, et[i], 4'h0);
    end
    acc(1'b0, 8'h48, 32'h0, 32'h0000_004f, 4'h0);
    chk_data(frame_packets, 32'h0000_004f);
    chk_data({region_width, region_height}, 32'h0290_01eb);
    chk_data({region_left, region_top}, 32'h0);
  endtask

  task automatic t_region();
    acc(1'b1, 8'h0c, 32'h000a_0007, 32'h0, 4'h0);
    acc(1'b0, 8'h34, 32'h0, 32'h0000_0046, 4'h0);
    acc(1'b0, 8'h3c, 32'h0, 32'h0000_0048, 4'h0);
    acc(1'b0, 8'h40, 32'h0, 32'h0004_0048, 4'h0);
    acc(1'b0, 8'h48, 32'h0, 32'h0000_0001, 4'h0);
    chk_data(frame_packets, 32'h1);
    acc(1'b1, 8'h0c, 32'h0290_01eb, 32'h0, 4'h0);
  endtask

  task automatic t_packet();
    acc(1'b1, 8'h44, 32'h0100_0000, 32'h0, 4'h0);
    acc(1'b0, 8'h44, 32'h0, 32'h0100_0ffc, 4'h0);
    acc(1'b0, 8'h48, 32'h0, 32'h0000_04eb, 4'h0);
    chk_data({16'h0, packet_bytes}, 32'h0100);
    acc(1'b1, 8'h44, 32'h0080_0000, 32'h0, 4'h0);
    acc(1'b0, 8'h48, 32'h0, 32'h0000_09d5, 4'h0);
    chk_data(frame_packets, 32'h09d5);
  endtask

  task automatic t_vga();
    acc(1'b1, 8'h0c, 32'h0280_01e0, 32'h0, 4'h0);
    acc(1'b1, 8'h08, 32'h0008_0005, 32'h0, 4'h0);
    chk_data({31'h0, region_is_vga}, 32'h1);
    chk_data({region_left, region_top}, 32'h0008_0005);
    acc(1'b1, 8'h08, 32'h0, 32'h0, 4'h0);
    chk_data({31'h0, region_is_vga}, 32'h0);
  endtask

  task automatic t_refuse();
    acc(1'b1, 8'h00, 32'h1234_5678, 32'h0, 4'h6);
    acc(1'b0, 8'h00, 32'h0, 32'h0290_01eb, 4'h0);
    acc(1'b0, 8'h18, 32'h0, 32'h0, 4'h7);
    acc(1'b0, 8'h02, 32'h0, 32'h0, 4'h7);
    acc(1'b1, 8'h10, 32'h0100_0000, 32'h0, 4'h0);
    acc(1'b0, 8'h10, 32'h0, 32'h0, 4'h0);
    acc(1'b0, 8'h54, 32'h0, 32'h0800_0000, 4'h0);
    base_r = 48'hffff_f1f0_0100;
    acc(1'b0, 8'h00, 32'h0, 32'h0, 4'h7);
    base_r = CIF_BASE;
  endtask

  initial begin
    sys_rst = 1'b1;
    base_r  = CIF_BASE;
    fails   = 0;
    checked = 0;
    cycles  = 0;
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    t_reset_values();
    t_region();
    t_packet();
    t_vga();
    t_refuse();
    tally_and_finish();
  end
endmodule

// ---- logic/cif_calc_if.sv ----
// Carrier between the register set and its two arithmetic helpers.
// Assumes one clock domain shared by all three modules.
interface cif_calc_if;
  logic [15:0] width;
  logic [15:0] height;
  logic [31:0] pixels;
  logic [31:0] total_bytes;
  logic [15:0] pkt_ceiling;
  logic        div_start;
  logic [31:0] dividend;
  logic [15:0] divisor;
  logic        div_done;
  logic [31:0] quotient;

  modport ctrl (output width, height, div_start, dividend, divisor,
                input  pixels, total_bytes, pkt_ceiling, div_done, quotient);
  modport calc (input  width, height,
                output pixels, total_bytes, pkt_ceiling);
  modport div  (input  div_start, dividend, divisor,
                output div_done, quotient);
endinterface

// ---- logic/cif_csr.sv ----
// Register set of one custom monochrome image mode, reached by quadlet
// reads and writes. Assumes requests are held until req_ready is seen.
//
// Notes on behaviour
// [R1] Registers sit at offsets from fixed base
// [R2] Largest size reads 656 by 491
// [R3] VGA window sits centred in the sensor
// [R4] Size steps read one pixel, one line
// [R5] Origin steps read one and one
// [R6] Reset origin zero, size at maximum
// [R7] Only mono 8, coding zero, is offered
// [R8] Offsets 024h and 058h read as zero
// [R9] Pixel count follows programmed region size
// [R10] Byte count covers data, padding, features
// [R11] Granule four bytes; ceiling tracks region size
// [R12] Suggested packet size reads 4092 bytes
// [R13] Host picks and writes the packet size
// [R14] Packet count recomputed; smaller packets, more
// [R15] Host keeps packet count within 4095
// [R16] Depth reads eight bits for mono 8
// [R17] Host keeps region within largest size
// [R18] Derived values settle before write completes
module cif_csr import cif_pkg::*; #(
  parameter logic [31:0] FEATURE_BYTES = 32'h0000_0000,
  parameter logic [15:0] PKT_CEIL_MAX  = PKT_CEIL_DEF
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // Quadlet request
  input  wire logic        req_valid,
  input  wire logic        req_write,
  input  wire logic [47:0] req_addr,
  input  wire logic [31:0] req_wdata,
  output logic             req_ready,
  // Response
  output logic             resp_valid,
  output logic [31:0]      resp_rdata,
  output logic [3:0]       resp_rcode,
  // Settings for the image pipeline
  output logic [15:0]      region_left,
  output logic [15:0]      region_top,
  output logic [15:0]      region_width,
  output logic [15:0]      region_height,
  output logic [15:0]      packet_bytes,
  output logic [31:0]      frame_packets,
  output logic             region_is_vga
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Packet count of the reset region, valid before any write
  localparam logic [31:0] BYTES_RST     = ((32'(MAX_W) * 32'(MAX_H) + 32'h0000_0003)
                                           & 32'hffff_fffc) + FEATURE_BYTES;
  localparam logic [31:0] PKT_COUNT_RST = (BYTES_RST + 32'(PKT_SIZE_RST) - 32'h0000_0001)
                                           / 32'(PKT_SIZE_RST);

  cif_calc_if cb ();

  cif_state_t  state_r;
  logic        req_ready_r;
  logic        resp_valid_r;
  logic [31:0] resp_rdata_r;
  logic [3:0]  resp_rcode_r;
  logic [15:0] origin_left_r;
  logic [15:0] origin_top_r;
  logic [15:0] dims_w_r;
  logic [15:0] dims_h_r;
  logic [7:0]  coding_r;
  logic [15:0] pkt_size_r;
  logic [31:0] pkt_count_r;
  logic        div_start_r;
  logic        region_is_vga_r;

  logic        taken;
  logic [7:0]  ofs;
  logic        hit;
  logic        known;
  logic        rw_ofs;
  logic [31:0] rd_data;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  always_comb begin
    taken  = req_valid && req_ready_r;
    ofs    = req_addr[7:0];
    hit    = (req_addr[47:8] == CIF_BASE[47:8]) && (req_addr[1:0] == 2'b00); // [R1]
    rw_ofs = (ofs == OFS_ORIGIN) || (ofs == OFS_DIMS) || (ofs == OFS_CODING)
             || (ofs == OFS_PKT_SIZE);
    known  = 1'b1;
    rd_data = 32'h0000_0000;
    case (ofs)
      OFS_LARGEST:     rd_data = {MAX_W, MAX_H};           // [R2]
      OFS_SIZE_STEP:   rd_data = {SIZE_STEP, SIZE_STEP};   // [R4]
      OFS_ORIGIN:      rd_data = {origin_left_r, origin_top_r};
      OFS_DIMS:        rd_data = {dims_w_r, dims_h_r};
      OFS_CODING:      rd_data = {coding_r, 24'h00_0000};
      OFS_CODING_CAPS: rd_data = CODING_CAP_MONO;          // [R7]
      OFS_CAPS_EXT:    rd_data = 32'h0000_0000;            // [R8]
      OFS_PIXELS:      rd_data = cb.pixels;                // [R9]
      OFS_BYTES_HI:    rd_data = 32'h0000_0000;            // [R10]
      OFS_BYTES_LO:    rd_data = cb.total_bytes;           // [R10]
      OFS_PKT_LIMITS:  rd_data = {PKT_GRANULE, cb.pkt_ceiling}; // [R11]
      OFS_PKT_SIZE:    rd_data = {pkt_size_r, PKT_SUGGESTED};   // [R12]
      OFS_PKT_COUNT:   rd_data = pkt_count_r;              // [R14]
      OFS_ORIGIN_STEP: rd_data = {POS_STEP, POS_STEP};     // [R5]
      OFS_DEPTH:       rd_data = {DEPTH_MONO8, 24'h00_0000};    // [R16]
      OFS_MOSAIC:      rd_data = 32'h0000_0000;            // [R8]
      default:         known   = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Writable settings
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      origin_left_r <= ORIGIN_RST;  // [R6]
      origin_top_r  <= ORIGIN_RST;  // [R6]
      dims_w_r      <= MAX_W;       // [R6]
      dims_h_r      <= MAX_H;       // [R6]
      coding_r      <= CODING_MONO8;
      pkt_size_r    <= PKT_SIZE_RST;
    end else if (taken && req_write && hit) begin
      case (ofs)
        OFS_ORIGIN: begin
          origin_left_r <= req_wdata[31:16];
          origin_top_r  <= req_wdata[15:0];
        end
        OFS_DIMS: begin
          dims_w_r <= req_wdata[31:16];
          dims_h_r <= req_wdata[15:0];
        end
        OFS_CODING: begin
          // Unsupported codings leave the setting unchanged
          if (req_wdata[31:24] == CODING_MONO8) begin
            coding_r <= CODING_MONO8; // [R7]
          end
        end
        OFS_PKT_SIZE: pkt_size_r <= req_wdata[31:16]; // [R13]
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Sequencing of requests and recomputation
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_r     <= ST_IDLE;
      div_start_r <= 1'b0;
    end else begin
      div_start_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (taken && req_write && hit && rw_ofs) begin
            state_r <= ST_CALC; // [R18]
          end
        end
        ST_CALC: begin
          state_r     <= ST_DIV;
          div_start_r <= 1'b1;
        end
        ST_DIV: begin
          if (cb.div_done) begin
            state_r <= ST_RESP;
          end
        end
        ST_RESP: state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Packet count is the rounded-up quotient of bytes by packet size
  assign cb.width    = dims_w_r;
  assign cb.height   = dims_h_r;
  assign cb.div_start = div_start_r;
  assign cb.divisor  = pkt_size_r;
  assign cb.dividend = cb.total_bytes + {16'h0000, pkt_size_r} - 32'h0000_0001;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pkt_count_r <= PKT_COUNT_RST; // [R14]
    end else if (state_r == ST_DIV && cb.div_done) begin
      if (pkt_size_r == 16'h0000) begin
        pkt_count_r <= 32'h0000_0000;
      end else begin
        pkt_count_r <= cb.quotient; // [R14]
      end
    end
  end

  // ----------------------------------------------------------------
  // Responses
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      req_ready_r  <= 1'b0;
      resp_valid_r <= 1'b0;
      resp_rdata_r <= 32'h0000_0000;
      resp_rcode_r <= RCODE_COMPLETE;
    end else begin
      resp_valid_r <= 1'b0;
      if (taken) begin
        req_ready_r <= 1'b0;
        if (!hit || !known) begin
          resp_valid_r <= 1'b1;
          resp_rdata_r <= 32'h0000_0000;
          resp_rcode_r <= RCODE_ADDR_ERR; // [R1]
        end else if (!req_write) begin
          resp_valid_r <= 1'b1;
          resp_rdata_r <= rd_data;
          resp_rcode_r <= RCODE_COMPLETE;
        end else if (!rw_ofs) begin
          resp_valid_r <= 1'b1;
          resp_rdata_r <= 32'h0000_0000;
          resp_rcode_r <= RCODE_TYPE_ERR;
        end
      end else if (state_r == ST_DIV && cb.div_done) begin
        // Write completes only once every derived value has settled
        resp_valid_r <= 1'b1; // [R18]
        resp_rdata_r <= 32'h0000_0000;
        resp_rcode_r <= RCODE_COMPLETE;
      end else if (state_r == ST_IDLE && !req_ready_r && !resp_valid_r) begin
        req_ready_r <= 1'b1;
      end else if (resp_valid_r) begin
        req_ready_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      region_is_vga_r <= 1'b0;
    end else begin
      region_is_vga_r <= (origin_left_r == VGA_LEFT) && (origin_top_r == VGA_TOP)
                         && (dims_w_r == VGA_W) && (dims_h_r == VGA_H); // [R3]
    end
  end

  assign req_ready     = req_ready_r;
  assign resp_valid    = resp_valid_r;
  assign resp_rdata    = resp_rdata_r;
  assign resp_rcode    = resp_rcode_r;
  assign region_left   = origin_left_r;
  assign region_top    = origin_top_r;
  assign region_width  = dims_w_r;
  assign region_height = dims_h_r;
  assign packet_bytes  = pkt_size_r;
  assign frame_packets = pkt_count_r;
  assign region_is_vga = region_is_vga_r;

  // ----------------------------------------------------------------
  // Arithmetic helpers
  // ----------------------------------------------------------------
  cif_pix_calc #(
    .FEATURE_BYTES (FEATURE_BYTES),
    .PKT_CEIL_MAX  (PKT_CEIL_MAX)
  ) u_calc (
    .clock   (clock),
    .sys_rst (sys_rst),
    .cb      (cb)
  );

  cif_pkt_div u_div (
    .clock   (clock),
    .sys_rst (sys_rst),
    .db      (cb)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  localparam int WR_LAT = 36;
  localparam int WR_GAP = WR_LAT - 8;

  default clocking cb_chk @(posedge clock); endclocking
  default disable iff (sys_rst);

  logic        rd_ok;
  logic [47:0] cnt_hi;
  logic [47:0] cnt_lo;

  always_comb begin
    rd_ok  = taken && !req_write && hit;
    cnt_hi = {16'h0000, pkt_count_r} * {32'h0000_0000, pkt_size_r};
    cnt_lo = ({16'h0000, pkt_count_r} - 48'h1) * {32'h0000_0000, pkt_size_r};
  end

  sequence s_rw_write;
    taken && req_write && hit && rw_ofs;
  endsequence

  sequence s_settled;
    resp_valid_r && resp_rcode_r == RCODE_COMPLETE
    && cb.pixels == dims_w_r * dims_h_r && cnt_hi >= {16'h0000, cb.total_bytes};
  endsequence

  chk_base_decode: assert property (taken && !hit |=> resp_valid_r // [R1]
    && resp_rcode_r == RCODE_ADDR_ERR) else $error("off-base access not refused");
  chk_largest_dims: assert property (rd_ok && ofs == OFS_LARGEST |=> // [R2]
    resp_rdata_r == {MAX_W, MAX_H}) else $error("largest size wrong");
  chk_vga_centre: assert property (region_is_vga_r |-> // [R3]
    $past(origin_left_r) * 2 + VGA_W == MAX_W && $past(dims_h_r) == VGA_H)
    else $error("VGA window not centred");
  chk_size_step: assert property (rd_ok && ofs == OFS_SIZE_STEP |=> // [R4]
    resp_rdata_r == {SIZE_STEP, SIZE_STEP}) else $error("size step wrong");
  chk_origin_step: assert property (rd_ok && ofs == OFS_ORIGIN_STEP |=> // [R5]
    resp_rdata_r == {POS_STEP, POS_STEP}) else $error("origin step wrong");
  chk_reset_values: assert property ($past(sys_rst) |-> origin_left_r == 16'h0000 // [R6]
    && origin_top_r == 16'h0000 && dims_w_r == MAX_W && dims_h_r == MAX_H)
    else $error("reset values wrong");
  chk_coding_only: assert property (rd_ok && ofs == OFS_CODING |=> // [R7]
    resp_rdata_r[31:24] == CODING_MONO8) else $error("coding not mono 8");
  chk_unused_zero: assert property (rd_ok && (ofs == OFS_CAPS_EXT || ofs == OFS_MOSAIC)
    |=> resp_rdata_r == 32'h0000_0000 && resp_rcode_r == RCODE_COMPLETE) // [R8]
    else $error("unused register not zero");
  chk_pixel_count: assert property (req_ready_r |-> // [R9]
    cb.pixels == dims_w_r * dims_h_r) else $error("pixel count stale");
  chk_byte_count: assert property (req_ready_r |-> cb.total_bytes[1:0] == 2'b00 // [R10]
    && cb.total_bytes >= cb.pixels) else $error("byte count not padded");
  chk_pkt_limits: assert property (rd_ok && ofs == OFS_PKT_LIMITS |=> // [R11]
    resp_rdata_r[31:16] == PKT_GRANULE && resp_rdata_r[15:0] <= PKT_CEIL_MAX)
    else $error("packet limits wrong");
  chk_ceiling_track: assert property (req_ready_r |-> cb.pkt_ceiling[1:0] == 2'b00 // [R11]
    && {16'h0000, cb.pkt_ceiling} <= cb.total_bytes)
    else $error("packet ceiling exceeds frame");
  chk_suggested: assert property (rd_ok && ofs == OFS_PKT_SIZE |=> // [R12]
    resp_rdata_r == {$past(pkt_size_r), PKT_SUGGESTED}) else $error("packet size read");
  chk_pkt_count: assert property (req_ready_r && pkt_size_r != 16'h0000 |-> // [R14]
    cnt_hi >= {16'h0000, cb.total_bytes} && cnt_lo < {16'h0000, cb.total_bytes})
    else $error("packet count not rounded up");
  chk_depth_bits: assert property (rd_ok && ofs == OFS_DEPTH |=> // [R16]
    resp_rdata_r[31:24] == DEPTH_MONO8) else $error("depth wrong");
  chk_write_settle: assert property (s_rw_write |=> !req_ready_r[*8] ##WR_GAP // [R18]
    s_settled) else $error("write completed before derived values");
  chk_write_quiet: assert property (s_rw_write |=> !resp_valid_r[*8]) // [R18]
    else $error("early write response");
endmodule

// ---- logic/cif_pix_calc.sv ----
// Frame size arithmetic: pixel count, padded byte count, packet ceiling.
// Assumes one byte per pixel, the only coding of this mode.
module cif_pix_calc import cif_pkg::*; #(
  parameter logic [31:0] FEATURE_BYTES = 32'h0000_0000,
  parameter logic [15:0] PKT_CEIL_MAX  = PKT_CEIL_DEF
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Carrier
  cif_calc_if.calc cb
);
  logic [31:0] pixels_nxt;
  logic [31:0] total_nxt;
  logic [31:0] pixels_r;
  logic [31:0] total_r;
  logic [15:0] ceil_r;

  always_comb begin
    pixels_nxt = cb.width * cb.height;
    // Pad image to whole quadlets, then add appended feature data
    total_nxt  = ((pixels_nxt + 32'h0000_0003) & 32'hffff_fffc) + FEATURE_BYTES;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pixels_r <= 32'h0000_0000;
      total_r  <= 32'h0000_0000;
      ceil_r   <= 16'h0000;
    end else begin
      pixels_r <= pixels_nxt;
      total_r  <= total_nxt;
      if (total_nxt > {16'h0000, PKT_CEIL_MAX}) begin
        ceil_r <= PKT_CEIL_MAX & ~(PKT_GRANULE - 16'h0001);
      end else begin
        ceil_r <= total_nxt[15:0] & ~(PKT_GRANULE - 16'h0001);
      end
    end
  end

  assign cb.pixels      = pixels_r;
  assign cb.total_bytes = total_r;
  assign cb.pkt_ceiling = ceil_r;
endmodule

// ---- logic/cif_pkg.sv ----
// Constants and types for the custom image format register set.
// Assumes quadlet requests carrying a node-relative 48-bit address.
package cif_pkg;

  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam logic [47:0] CIF_BASE        = 48'hffff_f1f0_0300;
  localparam logic [7:0]  OFS_LARGEST     = 8'h00;
  localparam logic [7:0]  OFS_SIZE_STEP   = 8'h04;
  localparam logic [7:0]  OFS_ORIGIN      = 8'h08;
  localparam logic [7:0]  OFS_DIMS        = 8'h0c;
  localparam logic [7:0]  OFS_CODING      = 8'h10;
  localparam logic [7:0]  OFS_CODING_CAPS = 8'h14;
  localparam logic [7:0]  OFS_CAPS_EXT    = 8'h24;
  localparam logic [7:0]  OFS_PIXELS      = 8'h34;
  localparam logic [7:0]  OFS_BYTES_HI    = 8'h38;
  localparam logic [7:0]  OFS_BYTES_LO    = 8'h3c;
  localparam logic [7:0]  OFS_PKT_LIMITS  = 8'h40;
  localparam logic [7:0]  OFS_PKT_SIZE    = 8'h44;
  localparam logic [7:0]  OFS_PKT_COUNT   = 8'h48;
  localparam logic [7:0]  OFS_ORIGIN_STEP = 8'h4c;
  localparam logic [7:0]  OFS_DEPTH       = 8'h54;
  localparam logic [7:0]  OFS_MOSAIC      = 8'h58;

  // ----------------------------------------------------------------
  // Field values and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] MAX_W           = 16'h0290;
  localparam logic [15:0] MAX_H           = 16'h01eb;
  localparam logic [15:0] VGA_W           = 16'h0280;
  localparam logic [15:0] VGA_H           = 16'h01e0;
  localparam logic [15:0] VGA_LEFT        = 16'((MAX_W - VGA_W) >> 1);
  localparam logic [15:0] VGA_TOP         = 16'((MAX_H - VGA_H) >> 1);
  localparam logic [15:0] SIZE_STEP       = 16'h0001;
  localparam logic [15:0] POS_STEP        = 16'h0001;
  localparam logic [15:0] ORIGIN_RST      = 16'h0000;
  localparam logic [7:0]  CODING_MONO8    = 8'h00;
  localparam logic [31:0] CODING_CAP_MONO = 32'h8000_0000;
  localparam logic [15:0] PKT_GRANULE     = 16'h0004;
  localparam logic [15:0] PKT_SUGGESTED   = 16'h0ffc;
  localparam logic [15:0] PKT_CEIL_DEF    = 16'h0ffc;
  localparam logic [15:0] PKT_SIZE_RST    = 16'h0ffc;
  localparam logic [7:0]  DEPTH_MONO8     = 8'h08;
  localparam logic [5:0]  DIV_STEPS       = 6'h20;

  // ----------------------------------------------------------------
  // Response codes and states
  // ----------------------------------------------------------------
  localparam logic [3:0]  RCODE_COMPLETE  = 4'h0;
  localparam logic [3:0]  RCODE_TYPE_ERR  = 4'h6;
  localparam logic [3:0]  RCODE_ADDR_ERR  = 4'h7;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CALC = 2'b01,
    ST_DIV  = 2'b11,
    ST_RESP = 2'b10
  } cif_state_t;

endpackage

// ---- logic/cif_pkt_div.sv ----
// Restoring divider, one quotient bit per clock.
// Assumes start is a pulse and operands hold steady for that cycle.
module cif_pkt_div import cif_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Carrier
  cif_calc_if.div  db
);
  logic [31:0] num_r;
  logic [31:0] rem_r;
  logic [31:0] quot_r;
  logic [15:0] den_r;
  logic [5:0]  cnt_r;
  logic        done_r;
  logic [32:0] trial;

  always_comb begin
    trial = {rem_r, num_r[31]} - {17'h0_0000, den_r};
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      num_r  <= 32'h0000_0000;
      rem_r  <= 32'h0000_0000;
      quot_r <= 32'h0000_0000;
      den_r  <= 16'h0000;
      cnt_r  <= 6'h00;
      done_r <= 1'b0;
    end else if (db.div_start) begin
      num_r  <= db.dividend;
      den_r  <= db.divisor;
      rem_r  <= 32'h0000_0000;
      quot_r <= 32'h0000_0000;
      cnt_r  <= DIV_STEPS;
      done_r <= 1'b0;
    end else if (cnt_r != 6'h00) begin
      num_r <= {num_r[30:0], 1'b0};
      if (!trial[32]) begin
        rem_r  <= trial[31:0];
        quot_r <= {quot_r[30:0], 1'b1};
      end else begin
        rem_r  <= {rem_r[30:0], num_r[31]};
        quot_r <= {quot_r[30:0], 1'b0};
      end
      cnt_r  <= cnt_r - 6'h01;
      done_r <= (cnt_r == 6'h01);
    end else begin
      done_r <= 1'b0;
    end
  end

  assign db.div_done = done_r;
  assign db.quotient = quot_r;
endmodule
